/* core/umd_decoder.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - one linear space for fetches and data
// - segment number is address bits 23:16
// - page number is address bits 15:14
// - byte or word access, lane by bit 0
// - internal data areas live in segment zero
// - parts of register areas are bit addressable
// - fetch side owns flash and code ram
// - data side owns data ram and peripherals
// - cross-side traffic flagged for system bus
// - fetch and data decode run concurrently
// - protected code ram region refuses writes
// - data ram reached on its own path
// - register bank: 16 words or 16 bytes
// - top 256 bytes of dual-port ram bit addressable
// - register-mode dual-port access is bit addressable
// - standby ram has its own target
// - io area accesses flagged strictly ordered
// - one flash sector kept from users
// - two 512-byte function register areas decoded
// - local peripheral bus goes via bus controller
module umd_decoder #(
  parameter int GPR_NUM_W = umd_pkg::GPR_NUM_W
) (
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire logic                 fetchReq,
  input  wire logic [23:0]          fetchAddr,
  input  wire logic                 dataReq,
  input  wire logic [23:0]          dataAddr,
  input  wire logic                 dataWrite,
  input  wire logic                 dataWord,
  input  wire logic                 dataGpr,
  input  wire logic                 gprByte,
  input  wire logic [GPR_NUM_W-1:0] gprNum,
  input  wire logic [15:0]          ctxPtr,
  input  wire logic                 codeRamProtEn,
  input  wire logic [15:0]          codeRamProtSize,
  input  wire logic                 clkSrcSys,
  input  wire logic                 refPinOut,
  input  wire logic                 fastPadEn,
  output logic [1:0]                resValid,
  output umd_pkg::umd_target_t      resTarget [2],
  output umd_pkg::umd_unit_t        resOwner [2],
  output logic [23:0]               resOffset [2],
  output logic [7:0]                resSegment [2],
  output logic [1:0]                resPage [2],
  output logic [1:0]                resLanes [2],
  output logic [1:0]                resTrap,
  output logic [1:0]                resCross,
  output logic [1:0]                resBitAddr,
  output logic [1:0]                resStrict,
  output logic [1:0]                resMirror,
  output logic [1:0]                resWriteReject,
  output logic                      refClkOutEn
);

  logic [15:0] gprIndex;
  logic [15:0] gprAddr;
  logic [23:0] portAddr [2];
  logic [1:0]  portReq;
  logic [1:0]  portWrite;
  logic [1:0]  portWord;
  logic [1:0]  portGpr;

  // word registers sit two bytes apart, byte registers one apart
  assign gprIndex = gprByte ? {{(16-GPR_NUM_W){1'b0}}, gprNum}
                            : {{(15-GPR_NUM_W){1'b0}}, gprNum, 1'b0};
  assign gprAddr  = ctxPtr + gprIndex;

  // both ports look at the same single address map
  assign portAddr[umd_pkg::PORT_FETCH]  = fetchAddr;
  assign portAddr[umd_pkg::PORT_DATA]   = dataGpr ? {umd_pkg::SYS_SEGMENT, gprAddr}
                                                  : dataAddr;
  assign portReq[umd_pkg::PORT_FETCH]   = fetchReq;
  assign portReq[umd_pkg::PORT_DATA]    = dataReq;
  assign portWrite[umd_pkg::PORT_FETCH] = 1'b0;
  assign portWrite[umd_pkg::PORT_DATA]  = dataWrite;
  assign portWord[umd_pkg::PORT_FETCH]  = 1'b1;
  // word registers always move a whole word, byte registers one lane
  assign portWord[umd_pkg::PORT_DATA]   = dataGpr ? !gprByte : dataWord;
  assign portGpr[umd_pkg::PORT_FETCH]   = 1'b0;
  assign portGpr[umd_pkg::PORT_DATA]    = dataGpr;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  generate
    for (genvar p = 0; p < umd_pkg::NUM_PORTS; p++) begin : g_port
      umd_dec_if dec ();
      umd_pkg::umd_unit_t reqUnit;
      logic               protHit;
      logic               isProgMem;
      logic               dpGpr;

      assign dec.addr  = portAddr[p];
      assign reqUnit   = (p == umd_pkg::PORT_FETCH) ? umd_pkg::UNIT_FETCH
                                                    : umd_pkg::UNIT_DATA;
      assign protHit   = codeRamProtEn && (dec.offset[15:0] < codeRamProtSize);
      assign isProgMem = (dec.target == umd_pkg::TGT_CODE_RAM) ||
                         (dec.target == umd_pkg::TGT_EMU_CRAM);
      assign dpGpr     = portGpr[p] && (dec.target == umd_pkg::TGT_DUAL_PORT_RAM);

      umd_region_lookup u_lookup (
        .dec (dec.lookup)
      );

      // each port has its own result registers so both move each cycle
      always_ff @(posedge mclk) begin
        if (srst) begin
          resValid[p] <= 1'b0;
        end else begin
          resValid[p] <= portReq[p];
        end
      end

      always_ff @(posedge mclk) begin
        if (srst) begin
          resTarget[p]  <= umd_pkg::TGT_EXT_MEM;
          resOwner[p]   <= umd_pkg::UNIT_FETCH;
          resOffset[p]  <= 24'h000000;
          resSegment[p] <= 8'h00;
          resPage[p]    <= 2'b00;
          resMirror[p]  <= 1'b0;
          resStrict[p]  <= 1'b0;
        end else if (portReq[p]) begin
          resTarget[p]  <= dec.target;
          resOwner[p]   <= dec.owner;
          resOffset[p]  <= dec.offset;
          resSegment[p] <= portAddr[p][umd_pkg::SEG_MSB:umd_pkg::SEG_LSB];
          resPage[p]    <= portAddr[p][umd_pkg::PAGE_MSB:umd_pkg::PAGE_LSB];
          resMirror[p]  <= dec.mirrored;
          resStrict[p]  <= dec.strictOrder;
        end
      end

      always_ff @(posedge mclk) begin
        if (srst) begin
          resLanes[p] <= 2'b00;
        end else if (portReq[p]) begin
          if (portWord[p]) begin
            resLanes[p] <= umd_pkg::LANES_WORD;
          end else begin
            resLanes[p] <= portAddr[p][0] ? umd_pkg::LANES_HIGH
                                          : umd_pkg::LANES_LOW;
          end
        end
      end

      always_ff @(posedge mclk) begin
        if (srst) begin
          resTrap[p]    <= 1'b0;
          resCross[p]   <= 1'b0;
          resBitAddr[p] <= 1'b0;
        end else if (portReq[p]) begin
          resTrap[p]    <= (dec.target == umd_pkg::TGT_TRAP);
          // trapped requests never leave their own side
          resCross[p]   <= (dec.target != umd_pkg::TGT_TRAP) &&
                           (dec.owner != reqUnit);
          resBitAddr[p] <= dec.bitArea || dpGpr;
        end
      end

      always_ff @(posedge mclk) begin
        if (srst) begin
          resWriteReject[p] <= 1'b0;
        end else if (portReq[p]) begin
          resWriteReject[p] <= portWrite[p] && (
                               (isProgMem && protHit) ||
                               (dec.target == umd_pkg::TGT_FLASH));
        end
      end

      seg_field_a: assert property (
        portReq[p] |=> resValid[p] && (resSegment[p] == $past(portAddr[p][23:16])))
        else $error("segment field does not follow address bits 23:16");

      page_field_a: assert property (
        portReq[p] |=> resPage[p] == $past(portAddr[p][15:14]))
        else $error("page field does not follow address bits 15:14");

      trap_area_a: assert property (
        portReq[p] && (portAddr[p] >= umd_pkg::TRAP_HI_LO) &&
        (portAddr[p] < umd_pkg::IMB_LO) |=> resTrap[p] && !resCross[p])
        else $error("reserved top area did not trap");

      mirror_fold_a: assert property (
        portReq[p] && umd_pkg::umd_in(portAddr[p], umd_pkg::CRAM_MIR_LO,
                                      umd_pkg::CRAM_MIR_HI)
        |=> resTarget[p] == umd_pkg::TGT_CODE_RAM && resMirror[p] &&
            resOffset[p] == {8'h00, $past(portAddr[p][15:0])})
        else $error("code ram mirror not folded");

      io_strict_a: assert property (
        portReq[p] |=> resStrict[p] ==
          $past(umd_pkg::umd_in(portAddr[p], umd_pkg::EXTIO_LO, umd_pkg::EXTIO_HI)))
        else $error("strict order flag wrong for io area");

      flash_sector_a: assert property (
        portReq[p] && umd_pkg::umd_in(portAddr[p], umd_pkg::FLASH_SEC_LO,
                                      umd_pkg::FLASH_SEC_HI) |=> resTrap[p])
        else $error("reserved flash sector reachable");

      valid_pulse_a: assert property (
        !portReq[p] |=> !resValid[p])
        else $error("result valid without request");
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (srst) begin
      refClkOutEn <= 1'b0;
    end else begin
      // the reference clock only leaves once all three settings are made
      refClkOutEn <= clkSrcSys && refPinOut && fastPadEn;
    end
  end

  lane_sel_a: assert property (
    dataReq && !dataWord && !dataGpr |=>
      resLanes[1] == ($past(dataAddr[0]) ? umd_pkg::LANES_HIGH : umd_pkg::LANES_LOW))
    else $error("byte lane does not follow address bit 0");

  cross_bus_a: assert property (
    fetchReq && umd_pkg::umd_in(fetchAddr, umd_pkg::DRAM_LO, umd_pkg::DRAM_HI)
    |=> resCross[0] && resOwner[0] == umd_pkg::UNIT_DATA)
    else $error("fetch from data ram not routed over system bus");

  prot_reject_a: assert property (
    dataReq && dataWrite && !dataGpr && codeRamProtEn &&
    umd_pkg::umd_in(dataAddr, umd_pkg::CRAM_LO, umd_pkg::CRAM_HI) &&
    (dataAddr[15:0] < codeRamProtSize) |=> resWriteReject[1] && resCross[1])
    else $error("protected code ram write not rejected");

  gpr_bit_a: assert property (
    dataReq && dataGpr && (ctxPtr >= 16'hf600) && (ctxPtr <= 16'hfd00)
    |=> resBitAddr[1] && resTarget[1] == umd_pkg::TGT_DUAL_PORT_RAM)
    else $error("register access in dual-port ram not bit addressable");

  gpr_addr_a: assert property (
    dataReq && dataGpr && gprByte && (ctxPtr == 16'hf600) |=>
      resOffset[1] == {20'h00000, $past(gprNum)} && resLanes[1] != umd_pkg::LANES_WORD)
    else $error("byte register address wrong");

  sys_seg_a: assert property (
    dataReq && !dataGpr && (dataAddr[23:16] != 8'h00) |=>
      !(resTarget[1] inside {umd_pkg::TGT_SFR, umd_pkg::TGT_EXTENDED_FUNCTION_REGS,
                             umd_pkg::TGT_DUAL_PORT_RAM, umd_pkg::TGT_DATA_RAM}))
    else $error("internal data area decoded outside segment zero");

  refclk_a: assert property (
    !fastPadEn |=> !refClkOutEn)
    else $error("reference clock out without fast pad");

endmodule : umd_decoder

/* core/umd_pkg.sv */
package umd_pkg;

  localparam int ADDR_W     = 24;
  localparam int SEG_MSB    = 23;
  localparam int SEG_LSB    = 16;
  localparam int PAGE_MSB   = 15;
  localparam int PAGE_LSB   = 14;
  localparam int PORT_FETCH = 0;
  localparam int PORT_DATA  = 1;
  localparam int NUM_PORTS  = 2;
  localparam int GPR_NUM_W  = 4;

  localparam logic [7:0]  SYS_SEGMENT   = 8'h00;
  localparam logic [15:0] CODE_RAM_SIZE = 16'hffff;
  localparam logic [1:0]  LANES_WORD    = 2'b11;
  localparam logic [1:0]  LANES_LOW     = 2'b01;
  localparam logic [1:0]  LANES_HIGH    = 2'b10;

  // area boundaries, inclusive
  localparam logic [23:0] IMB_LO       = 24'hffff00;
  localparam logic [23:0] TRAP_HI_LO   = 24'hf00000;
  localparam logic [23:0] EMU_MIR_LO   = 24'he90000;
  localparam logic [23:0] EMU_MIR_HI   = 24'hefffff;
  localparam logic [23:0] EMU_CRAM_LO  = 24'he80000;
  localparam logic [23:0] EMU_CRAM_HI  = 24'he8ffff;
  localparam logic [23:0] CRAM_MIR_LO  = 24'he10000;
  localparam logic [23:0] CRAM_MIR_HI  = 24'he7ffff;
  localparam logic [23:0] CRAM_LO      = 24'he00000;
  localparam logic [23:0] CRAM_HI      = 24'he0ffff;
  localparam logic [23:0] PMEM_RSV_LO  = 24'hcc0000;
  localparam logic [23:0] PMEM_RSV_HI  = 24'hdfffff;
  localparam logic [23:0] FLASH_LO     = 24'hc00000;
  localparam logic [23:0] FLASH_HI     = 24'hcbffff;
  localparam logic [23:0] FLASH_SEC_LO = 24'hc3f000;
  localparam logic [23:0] FLASH_SEC_HI = 24'hc3ffff;
  localparam logic [23:0] EXTIO_LO     = 24'h200000;
  localparam logic [23:0] EXTIO_HI     = 24'h3fffff;
  localparam logic [23:0] LXB_HI       = 24'h2057ff;
  localparam logic [23:0] SFR_LO       = 24'h00fe00;
  localparam logic [23:0] SFR_BIT_LO   = 24'h00ff00;
  localparam logic [23:0] SFR_HI       = 24'h00ffff;
  localparam logic [23:0] DUAL_PORT_RAM_LO     = 24'h00f600;
  localparam logic [23:0] DUAL_PORT_RAM_BIT_LO = 24'h00fd00;
  localparam logic [23:0] DUAL_PORT_RAM_HI     = 24'h00fdff;
  localparam logic [23:0] DPR_RSV_LO   = 24'h00f200;
  localparam logic [23:0] DPR_RSV_HI   = 24'h00f5ff;
  localparam logic [23:0] EXTENDED_FUNCTION_REGS_LO      = 24'h00f000;
  localparam logic [23:0] EXTENDED_FUNCTION_REGS_BIT_LO  = 24'h00f100;
  localparam logic [23:0] EXTENDED_FUNCTION_REGS_HI      = 24'h00f1ff;
  localparam logic [23:0] EXTRA_FUNCTION_REGS_LO      = 24'h00e000;
  localparam logic [23:0] EXTRA_FUNCTION_REGS_HI      = 24'h00efff;
  localparam logic [23:0] DRAM_LO      = 24'h00a000;
  localparam logic [23:0] DRAM_HI      = 24'h00dfff;
  localparam logic [23:0] DRAM_RSV_LO  = 24'h008000;
  localparam logic [23:0] DRAM_RSV_HI  = 24'h009fff;
  localparam logic [23:0] STANDBY_RAM_LO     = 24'h008000;
  localparam logic [23:0] STANDBY_RAM_HI     = 24'h0083ff;

  typedef enum logic [3:0] {
    TGT_EXT_MEM  = 4'h0,
    TGT_EXT_IO   = 4'h1,
    TGT_LOCAL_PERIPHERAL_BUS    = 4'h2,
    TGT_FLASH    = 4'h3,
    TGT_CODE_RAM = 4'h4,
    TGT_EMU_CRAM = 4'h5,
    TGT_DATA_RAM = 4'h6,
    TGT_DUAL_PORT_RAM    = 4'h7,
    TGT_SFR      = 4'h8,
    TGT_EXTENDED_FUNCTION_REGS     = 4'h9,
    TGT_EXTRA_FUNCTION_REGS     = 4'ha,
    TGT_STANDBY  = 4'hb,
    TGT_IMB      = 4'hc,
    TGT_TRAP     = 4'hd
  } umd_target_t;

  typedef enum logic [0:0] {
    UNIT_FETCH = 1'b0,
    UNIT_DATA  = 1'b1
  } umd_unit_t;

  function automatic logic umd_in(input logic [23:0] a,
                                  input logic [23:0] lo,
                                  input logic [23:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : umd_in

endpackage : umd_pkg

/* core/umd_dec_if.sv */
`timescale 1ns/1ps
interface umd_dec_if;
  logic [23:0]         addr;
  umd_pkg::umd_target_t target;
  umd_pkg::umd_unit_t  owner;
  logic [23:0]         offset;
  logic                bitArea;
  logic                strictOrder;
  logic                mirrored;

  modport lookup (
    input  addr,
    output target,
    output owner,
    output offset,
    output bitArea,
    output strictOrder,
    output mirrored
  );
  modport user (
    output addr,
    input  target,
    input  owner,
    input  offset,
    input  bitArea,
    input  strictOrder,
    input  mirrored
  );
endinterface : umd_dec_if

/* core/umd_region_lookup.sv */
`timescale 1ns/1ps
module umd_region_lookup (
  umd_dec_if.lookup dec
);

  logic [23:0] a;
  logic        sys;

  assign a   = dec.addr;
  assign sys = (a[umd_pkg::SEG_MSB:umd_pkg::SEG_LSB] == umd_pkg::SYS_SEGMENT);

  always_comb begin
    dec.target      = umd_pkg::TGT_TRAP;
    dec.offset      = 24'h000000;
    dec.bitArea     = 1'b0;
    dec.strictOrder = 1'b0;
    dec.mirrored    = 1'b0;
    if (a >= umd_pkg::IMB_LO) begin
      dec.target = umd_pkg::TGT_IMB;
      dec.offset = a - umd_pkg::IMB_LO;
    end else if (a >= umd_pkg::TRAP_HI_LO) begin
      dec.target = umd_pkg::TGT_TRAP;
    end else if (umd_pkg::umd_in(a, umd_pkg::EMU_MIR_LO, umd_pkg::EMU_MIR_HI)) begin
      dec.target   = umd_pkg::TGT_EMU_CRAM;
      dec.offset   = {8'h00, a[15:0]};
      dec.mirrored = 1'b1;
    end else if (umd_pkg::umd_in(a, umd_pkg::EMU_CRAM_LO, umd_pkg::EMU_CRAM_HI)) begin
      dec.target = umd_pkg::TGT_EMU_CRAM;
      dec.offset = {8'h00, a[15:0]};
    end else if (umd_pkg::umd_in(a, umd_pkg::CRAM_MIR_LO, umd_pkg::CRAM_MIR_HI)) begin
      dec.target   = umd_pkg::TGT_CODE_RAM;
      dec.offset   = {8'h00, a[15:0]};
      dec.mirrored = 1'b1;
    end else if (umd_pkg::umd_in(a, umd_pkg::CRAM_LO, umd_pkg::CRAM_HI)) begin
      dec.target = umd_pkg::TGT_CODE_RAM;
      dec.offset = {8'h00, a[15:0]};
    end else if (umd_pkg::umd_in(a, umd_pkg::PMEM_RSV_LO, umd_pkg::PMEM_RSV_HI)) begin
      dec.target = umd_pkg::TGT_TRAP;
    end else if (umd_pkg::umd_in(a, umd_pkg::FLASH_SEC_LO, umd_pkg::FLASH_SEC_HI)) begin
      dec.target = umd_pkg::TGT_TRAP;
    end else if (umd_pkg::umd_in(a, umd_pkg::FLASH_LO, umd_pkg::FLASH_HI)) begin
      dec.target = umd_pkg::TGT_FLASH;
      dec.offset = a - umd_pkg::FLASH_LO;
    end else if (umd_pkg::umd_in(a, umd_pkg::EXTIO_LO, umd_pkg::EXTIO_HI)) begin
      // io area keeps strict access order
      dec.strictOrder = 1'b1;
      dec.offset      = a - umd_pkg::EXTIO_LO;
      dec.target      = (a <= umd_pkg::LXB_HI) ? umd_pkg::TGT_LOCAL_PERIPHERAL_BUS
                                               : umd_pkg::TGT_EXT_IO;
    end else if (!sys) begin
      dec.target = umd_pkg::TGT_EXT_MEM;
      dec.offset = a;
    end else if (umd_pkg::umd_in(a, umd_pkg::SFR_LO, umd_pkg::SFR_HI)) begin
      dec.target  = umd_pkg::TGT_SFR;
      dec.offset  = a - umd_pkg::SFR_LO;
      dec.bitArea = (a >= umd_pkg::SFR_BIT_LO);
    end else if (umd_pkg::umd_in(a, umd_pkg::DUAL_PORT_RAM_LO, umd_pkg::DUAL_PORT_RAM_HI)) begin
      dec.target  = umd_pkg::TGT_DUAL_PORT_RAM;
      dec.offset  = a - umd_pkg::DUAL_PORT_RAM_LO;
      dec.bitArea = (a >= umd_pkg::DUAL_PORT_RAM_BIT_LO);
    end else if (umd_pkg::umd_in(a, umd_pkg::DPR_RSV_LO, umd_pkg::DPR_RSV_HI)) begin
      dec.target = umd_pkg::TGT_TRAP;
    end else if (umd_pkg::umd_in(a, umd_pkg::EXTENDED_FUNCTION_REGS_LO, umd_pkg::EXTENDED_FUNCTION_REGS_HI)) begin
      dec.target  = umd_pkg::TGT_EXTENDED_FUNCTION_REGS;
      dec.offset  = a - umd_pkg::EXTENDED_FUNCTION_REGS_LO;
      dec.bitArea = (a >= umd_pkg::EXTENDED_FUNCTION_REGS_BIT_LO);
    end else if (umd_pkg::umd_in(a, umd_pkg::EXTRA_FUNCTION_REGS_LO, umd_pkg::EXTRA_FUNCTION_REGS_HI)) begin
      dec.target = umd_pkg::TGT_EXTRA_FUNCTION_REGS;
      dec.offset = a - umd_pkg::EXTRA_FUNCTION_REGS_LO;
    end else if (umd_pkg::umd_in(a, umd_pkg::DRAM_LO, umd_pkg::DRAM_HI)) begin
      dec.target = umd_pkg::TGT_DATA_RAM;
      dec.offset = a - umd_pkg::DRAM_LO;
    end else if (umd_pkg::umd_in(a, umd_pkg::STANDBY_RAM_LO, umd_pkg::STANDBY_RAM_HI)) begin
      dec.target = umd_pkg::TGT_STANDBY;
      dec.offset = a - umd_pkg::STANDBY_RAM_LO;
    end else if (umd_pkg::umd_in(a, umd_pkg::DRAM_RSV_LO, umd_pkg::DRAM_RSV_HI)) begin
      dec.target = umd_pkg::TGT_TRAP;
    end else begin
      dec.target = umd_pkg::TGT_EXT_MEM;
      dec.offset = a;
    end
  end

  // program memories belong to the fetch side, all else to the data side
  always_comb begin
    unique case (dec.target)
      umd_pkg::TGT_FLASH,
      umd_pkg::TGT_CODE_RAM,
      umd_pkg::TGT_EMU_CRAM: dec.owner = umd_pkg::UNIT_FETCH;
      default:               dec.owner = umd_pkg::UNIT_DATA;
    endcase
  end

endmodule : umd_region_lookup

/* verif/umd_core_model.sv */
`timescale 1ns/1ps
module umd_core_model (
  input  wire logic        mclk,
  output logic             fetchReq,
  output logic [23:0]      fetchAddr,
  output logic             dataReq,
  output logic [23:0]      dataAddr,
  output logic             dataWrite,
  output logic             dataWord,
  output logic             dataGpr,
  output logic             gprByte,
  output logic [3:0]       gprNum,
  output logic [15:0]      ctxPtr
);
  initial begin
    {fetchReq, dataReq, dataWrite, dataWord, dataGpr, gprByte} = 6'h00;
    {fetchAddr, dataAddr} = 48'h0;
    gprNum = 4'h0;
    ctxPtr = 16'h0;
  end

  // one decode per port and cycle; calls back to back keep the requests up
  task automatic issue(input logic fv, input logic [23:0] fa, input logic dv,
                       input logic [23:0] da, input logic [3:0] ctl, input logic [3:0] num,
                       input logic [15:0] cp);
    @(posedge mclk);
    fetchReq <= fv;
    dataReq <= dv;
    // an idle port shows inverted addresses so a stale value never decodes cleanly
    fetchAddr <= fv ? fa : ~fetchAddr;
    dataAddr <= dv ? da : ~dataAddr;
    {dataWrite, dataWord, dataGpr, gprByte} <= ctl;
    gprNum <= num;
    ctxPtr <= cp;
  endtask : issue

  task automatic idle();
    issue(1'b0, 24'h0, 1'b0, 24'h0, 4'h0, 4'h0, ~ctxPtr);
  endtask : idle
endmodule : umd_core_model

/* verif/umd_decoder_tb.sv */
`timescale 1ns/1ps
module umd_decoder_tb;
  localparam logic [23:0] LO [21] = '{umd_pkg::IMB_LO, umd_pkg::TRAP_HI_LO,
    umd_pkg::EMU_CRAM_LO, umd_pkg::CRAM_LO, umd_pkg::PMEM_RSV_LO, umd_pkg::FLASH_SEC_HI + 24'h1,
    umd_pkg::FLASH_SEC_LO, umd_pkg::FLASH_LO, umd_pkg::EXTIO_HI + 24'h1, umd_pkg::LXB_HI + 24'h1,
    umd_pkg::EXTIO_LO, umd_pkg::SFR_HI + 24'h1, umd_pkg::SFR_LO, umd_pkg::DUAL_PORT_RAM_LO,
    umd_pkg::DPR_RSV_LO, umd_pkg::EXTENDED_FUNCTION_REGS_LO, umd_pkg::EXTRA_FUNCTION_REGS_LO, umd_pkg::DRAM_LO,
    umd_pkg::STANDBY_RAM_HI + 24'h1, umd_pkg::STANDBY_RAM_LO, 24'h0};
  localparam logic [3:0] TG [21] = '{4'hc, 4'hd, 4'h5, 4'h4, 4'hd, 4'h3, 4'hd, 4'h3, 4'h0,
    4'h1, 4'h2, 4'h0, 4'h8, 4'h7, 4'hd, 4'h9, 4'ha, 4'h6, 4'hd, 4'hb, 4'h0};

  logic                 mclk, srst, fetchReq, dataReq, dataWrite, dataWord, dataGpr, gprByte;
  logic [23:0]          fetchAddr, dataAddr;
  logic [3:0]           gprNum;
  logic [15:0]          ctxPtr, codeRamProtSize, sz;
  logic                 codeRamProtEn, clkSrcSys, refPinOut, fastPadEn, refClkOutEn;
  logic [1:0]           resValid, resTrap, resCross, resBitAddr, resStrict, resMirror;
  logic [1:0]           resWriteReject;
  umd_pkg::umd_target_t resTarget [2];
  umd_pkg::umd_unit_t   resOwner [2];
  logic [23:0]          resOffset [2];
  logic [7:0]           resSegment [2];
  logic [1:0]           resPage [2];
  logic [1:0]           resLanes [2];
  logic [46:0]          q [2][$];
  logic [46:0]          mq [2][$];
  int                   nFail, samplesChecked;

  umd_core_model umd_core_model_inst (.mclk(mclk), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
    .dataReq(dataReq), .dataAddr(dataAddr), .dataWrite(dataWrite), .dataWord(dataWord),
    .dataGpr(dataGpr), .gprByte(gprByte), .gprNum(gprNum), .ctxPtr(ctxPtr));

  umd_decoder #(.GPR_NUM_W(4)) umd_decoder_inst (.mclk(mclk), .srst(srst),
    .fetchReq(fetchReq), .fetchAddr(fetchAddr), .dataReq(dataReq), .dataAddr(dataAddr),
    .dataWrite(dataWrite), .dataWord(dataWord), .dataGpr(dataGpr), .gprByte(gprByte),
    .gprNum(gprNum), .ctxPtr(ctxPtr), .codeRamProtEn(codeRamProtEn),
    .codeRamProtSize(codeRamProtSize), .clkSrcSys(clkSrcSys), .refPinOut(refPinOut),
    .fastPadEn(fastPadEn), .resValid(resValid), .resTarget(resTarget), .resOwner(resOwner),
    .resOffset(resOffset), .resSegment(resSegment), .resPage(resPage), .resLanes(resLanes),
    .resTrap(resTrap), .resCross(resCross), .resBitAddr(resBitAddr), .resStrict(resStrict),
    .resMirror(resMirror), .resWriteReject(resWriteReject), .refClkOutEn(refClkOutEn));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic final_report();
    if (nFail == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic chk(input logic [46:0] g, input logic [46:0] e);
    samplesChecked++;
    if (g !== e) begin
      nFail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // upper half is the compare mask, lower half the expected result vector
  function automatic logic [93:0] expect_of(input bit p, input logic [23:0] a,
                                            input logic wr, input logic wd, input logic general_purpose_register);
    logic [3:0]  t;
    logic        own, trap, bitA, ofsOk;
    logic [23:0] ofs;
    int          i;
    i = 0;
    while (LO[i] > a) i++;
    t = TG[i];
    trap = (t == 4'hd);
    own = !(t inside {4'h3, 4'h4, 4'h5});
    bitA = (general_purpose_register && t == 4'h7) || (a inside {[umd_pkg::SFR_BIT_LO:umd_pkg::SFR_HI],
      [umd_pkg::EXTENDED_FUNCTION_REGS_BIT_LO:umd_pkg::EXTENDED_FUNCTION_REGS_HI], [umd_pkg::DUAL_PORT_RAM_BIT_LO:umd_pkg::DUAL_PORT_RAM_HI]});
    ofsOk = t inside {4'h0, 4'h4, 4'h5, 4'hd};
    ofs = trap ? 24'h0 : ((t == 4'h0) ? a : {8'h00, a[15:0]});
    return {4'hf, 1'b1, {24{ofsOk}}, 12'hfff, 3'b111, 1'b1, 2'b11,
      t, own, ofs, a[23:16], a[15:14], (!p || wd) ? 2'b11 : (a[0] ? 2'b10 : 2'b01),
      trap, !trap && own != p, bitA, t inside {4'h1, 4'h2},
      a inside {[umd_pkg::CRAM_MIR_LO:umd_pkg::CRAM_MIR_HI], [umd_pkg::EMU_MIR_LO:umd_pkg::EMU_MIR_HI]},
      p && wr && (t == 4'h3 || (codeRamProtEn && t inside {4'h4, 4'h5}
        && a[15:0] < codeRamProtSize))};
  endfunction : expect_of

  // ctl is {write, word, register access, byte register}
  task automatic go(input logic fv, input logic [23:0] fa, input logic dv, input logic [23:0] da,
                    input logic [3:0] ctl, input logic [3:0] num, input logic [15:0] cp);
    logic [93:0] r;
    logic [23:0] ea;
    ea = ctl[1] ? {8'h00, cp + (ctl[0] ? 16'(num) : 16'(num) * 16'h2)} : da;
    if (fv) begin
      r = expect_of(1'b0, fa, 1'b0, 1'b1, 1'b0);
      q[0].push_back(r[46:0]);
      mq[0].push_back(r[93:47]);
    end
    if (dv) begin
      r = expect_of(1'b1, ea, ctl[3], ctl[1] ? !ctl[0] : ctl[2], ctl[1]);
      q[1].push_back(r[46:0]);
      mq[1].push_back(r[93:47]);
    end
    umd_core_model_inst.issue(fv, fa, dv, da, ctl, num, cp);
  endtask : go

  always @(negedge mclk) begin
    for (int p = 0; p < 2; p++) begin
      if (resValid[p] === 1'b1) begin
        if (q[p].size() == 0) begin
          chk(47'h1, 47'h0);
        end else begin
          chk({resTarget[p], resOwner[p], resOffset[p], resSegment[p], resPage[p], resLanes[p],
               resTrap[p], resCross[p], resBitAddr[p], resStrict[p], resMirror[p],
               resWriteReject[p]} & mq[p][0], q[p][0] & mq[p][0]);
          void'(q[p].pop_front());
          void'(mq[p].pop_front());
        end
      end
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    nFail++;
    final_report();
  end

  initial begin
    srst = 1'b1;
    {codeRamProtEn, clkSrcSys, refPinOut, fastPadEn} = 4'h0;
    codeRamProtSize = 16'h0;
    nFail = 0;
    samplesChecked = 0;
    void'($urandom(32'hb6ee));
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    chk(47'({resValid, refClkOutEn, resTarget[0], resTrap}), 47'h0);
    // both sides of every target boundary, both ports in the same cycle
    for (int i = 0; i < 21; i++) begin
      go(1'b1, LO[i], 1'b1, LO[i] - 24'h1, {2'($urandom), 2'b00}, 4'h0, 16'h0);
      go(1'b1, LO[i] - 24'h1, 1'b1, LO[i], {2'($urandom), 2'b00}, 4'h0, 16'h0);
    end
    for (int i = 0; i < 150; i++) begin
      if ($urandom % 4 == 0) umd_core_model_inst.idle();
      go(1'($urandom), 24'($urandom), 1'($urandom), 24'($urandom), {2'($urandom), 2'b00},
         4'h0, 16'h0);
    end
    // register bank inside, just below the bit-addressable top of, and outside the dual-port ram
    foreach (LO[j]) if (j < 3) begin
      for (int k = 0; k < 32; k++)
        go(1'b1, 24'($urandom), 1'b1, 24'($urandom), {3'b001, 1'(k)}, 4'(k >> 1),
           (j == 0) ? 16'hf600 : ((j == 1) ? 16'hfce0 : 16'ha000));
    end
    umd_core_model_inst.idle();
    sz = 16'h0100 + 16'($urandom % 32'hfe00);
    @(posedge mclk);
    codeRamProtEn <= 1'b1;
    codeRamProtSize <= sz;
    @(negedge mclk);
    for (int k = 0; k < 12; k++)
      go(1'b1, 24'($urandom), 1'b1, (k % 6 == 0) ? umd_pkg::CRAM_LO + 24'(sz) - 24'h1 :
         (k % 6 == 1) ? umd_pkg::CRAM_LO + 24'(sz) : (k % 6 == 2) ? umd_pkg::CRAM_MIR_LO + 24'(sz)
         - 24'h1 : (k % 6 == 3) ? umd_pkg::EMU_CRAM_LO : (k % 6 == 4) ? umd_pkg::EMU_MIR_HI
         : umd_pkg::FLASH_LO, {1'(k < 6), 3'b100}, 4'h0, 16'h0);
    umd_core_model_inst.idle();
    umd_core_model_inst.idle();
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      {clkSrcSys, refPinOut, fastPadEn} <= 3'(k);
      @(posedge mclk);
      @(negedge mclk);
      chk(47'(refClkOutEn), 47'(k == 7));
    end
    chk(47'(q[0].size() + q[1].size()), 47'h0);
    final_report();
  end
endmodule : umd_decoder_tb
